// ==== sym_cfg_pkg.sv ====
/*
 * constants for the transmit symbol pattern configuration block:
 * register indices, bus widths, field positions, reset values
 * and frequency figures.
 * assumes a 32-bit apb bus with one register per aligned word.
 */
package sym_cfg_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // printed register offsets kept as indices; byte address is index * 4
    localparam logic [7:0] IDX_FREQ   = 8'h4c;
    localparam logic [7:0] IDX_P0_HI  = 8'h4d;
    localparam logic [7:0] IDX_P0_LO  = 8'h4e;
    localparam logic [7:0] IDX_P1_HI  = 8'h4f;
    localparam logic [7:0] IDX_P1_LO  = 8'h50;
    localparam logic [7:0] IDX_P2     = 8'h51;
    localparam logic [7:0] IDX_P3     = 8'h52;
    localparam logic [7:0] IDX_LEN_01 = 8'h53;
    localparam logic [7:0] IDX_LEN_23 = 8'h54;

    // field positions of the frequency register
    localparam int unsigned UP_SC_POS  = 7;
    localparam int unsigned UP_BR_LSB  = 4;
    localparam int unsigned LO_SC_POS  = 3;
    localparam int unsigned LO_BR_LSB  = 0;

    // field positions of the length registers
    localparam int unsigned LEN1_LSB   = 4;
    localparam int unsigned LEN0_LSB   = 0;
    localparam int unsigned LEN3_LSB   = 4;
    localparam int unsigned LEN2_LSB   = 0;
    localparam logic [7:0]  LEN_23_MASK = 8'h77;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;

    // lowest bit-stream code that is not reserved
    localparam logic [2:0] BR_FIRST_OK = 3'h2;

    // frequencies in khz
    localparam logic [9:0] KHZ_26  = 10'd26;
    localparam logic [9:0] KHZ_53  = 10'd53;
    localparam logic [9:0] KHZ_106 = 10'd106;
    localparam logic [9:0] KHZ_212 = 10'd212;
    localparam logic [9:0] KHZ_424 = 10'd424;
    localparam logic [9:0] KHZ_848 = 10'd848;
    localparam logic [9:0] KHZ_NONE = 10'd0;

endpackage

// ==== sym_pattern_if.sv ====
/*
 * carrier between the register file and the pattern masking unit.
 * assumes both ends run on the same clock as the register file.
 */
`timescale 1ns/1ps
`default_nettype none

interface sym_pattern_if;
    logic [15:0] raw_zero;
    logic [15:0] raw_one;
    logic [7:0]  raw_two;
    logic [7:0]  raw_three;
    logic [3:0]  len_zero;
    logic [3:0]  len_one;
    logic [2:0]  len_two;
    logic [2:0]  len_three;
    logic [15:0] cut_zero;
    logic [15:0] cut_one;
    logic [7:0]  cut_two;
    logic [7:0]  cut_three;
    logic [4:0]  cnt_zero;
    logic [4:0]  cnt_one;
    logic [3:0]  cnt_two;
    logic [3:0]  cnt_three;

    modport cfg (
        output raw_zero, raw_one, raw_two, raw_three,
        output len_zero, len_one, len_two, len_three,
        input  cut_zero, cut_one, cut_two, cut_three,
        input  cnt_zero, cnt_one, cnt_two, cnt_three
    );

    modport mask (
        input  raw_zero, raw_one, raw_two, raw_three,
        input  len_zero, len_one, len_two, len_three,
        output cut_zero, cut_one, cut_two, cut_three,
        output cnt_zero, cnt_one, cnt_two, cnt_three
    );
endinterface

`default_nettype wire

// ==== sym_pattern_mask.sv ====
/*
 * masks each symbol pattern down to its valid bits and forms
 * the valid bit counts; purely combinational.
 * assumes raw patterns and length fields arrive over sym_pattern_if.
 */
`timescale 1ns/1ps
`default_nettype none

module sym_pattern_mask (
    sym_pattern_if.mask pif
);
    // valid bits start at bit 0; bits above the length read as zero
    for (genvar i = 0; i < 16; i++) begin : g_bit
        assign pif.cut_zero[i] = pif.raw_zero[i] & (4'(i) <= pif.len_zero);
        assign pif.cut_one[i]  = pif.raw_one[i] & (4'(i) <= pif.len_one);
        if (i < 8) begin : g_narrow
            assign pif.cut_two[i]   = pif.raw_two[i] & (3'(i) <= pif.len_two);
            assign pif.cut_three[i] = pif.raw_three[i] & (3'(i) <= pif.len_three);
        end
    end

    // field value plus one gives the count of valid bits
    assign pif.cnt_zero  = {1'b0, pif.len_zero} + 5'd1;
    assign pif.cnt_one   = {1'b0, pif.len_one} + 5'd1;
    assign pif.cnt_two   = {1'b0, pif.len_two} + 4'd1;
    assign pif.cnt_three = {1'b0, pif.len_three} + 4'd1;
endmodule

`default_nettype wire

// ==== tx_symbol_pattern_config.sv ====
/*
 * apb register file for the transmit encoder's user symbols:
 * frequency selections, four patterns and their valid lengths,
 * with masked patterns and decoded frequencies for the encoder.
 * assumes an apb master on ref_clk and an encoder that reads
 * the outputs as steady levels.
 */
// Our own choice: the APB interface to the registers.
// Overview of operation
// - bit 7 picks subcarrier of symbols two and three: 0 is 424, 1 is 848 khz
// - bits 6..4 pick bit rate of symbols two and three; 000, 001 reserved
// - bit 3 picks subcarrier of symbols zero and one: 0 is 424, 1 is 848 khz
// - bits 2..0 pick bit rate of symbols zero and one, same code table
// - symbol zero pattern is high byte over low byte, both read and write
// - symbol one pattern is high byte over low byte, both read and write
// - symbol two pattern is one read-write byte
// - symbol three pattern is one read-write byte
// - length bits 7..4 give symbol one valid bits as value plus one
// - length bits 3..0 give symbol zero valid bits as value plus one
// - bits 6..4 give symbol three valid bits plus one; bit 7 reserved
// - bits 2..0 give symbol two valid bits plus one; bit 3 reserved
`timescale 1ns/1ps
`default_nettype none

module tx_symbol_pattern_config
    import sym_cfg_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   upper_pair_subcarrier_sel,
    output logic      [2:0]        upper_pair_bitrate_sel,
    output logic                   lower_pair_subcarrier_sel,
    output logic      [2:0]        lower_pair_bitrate_sel,
    output logic      [9:0]        upper_pair_subcarrier_khz,
    output logic      [9:0]        upper_pair_bitrate_khz,
    output logic                   upper_pair_bitrate_ok,
    output logic      [9:0]        lower_pair_subcarrier_khz,
    output logic      [9:0]        lower_pair_bitrate_khz,
    output logic                   lower_pair_bitrate_ok,
    output logic      [15:0]       pattern_zero,
    output logic      [15:0]       pattern_one,
    output logic      [7:0]        pattern_two,
    output logic      [7:0]        pattern_three,
    output logic      [4:0]        pattern_zero_length,
    output logic      [4:0]        pattern_one_length,
    output logic      [3:0]        pattern_two_length,
    output logic      [3:0]        pattern_three_length
);

    // byte addresses of the registers
    localparam logic [ADDR_W-1:0] A_FREQ   = {2'b00, IDX_FREQ, 2'b00};
    localparam logic [ADDR_W-1:0] A_P0_HI  = {2'b00, IDX_P0_HI, 2'b00};
    localparam logic [ADDR_W-1:0] A_P0_LO  = {2'b00, IDX_P0_LO, 2'b00};
    localparam logic [ADDR_W-1:0] A_P1_HI  = {2'b00, IDX_P1_HI, 2'b00};
    localparam logic [ADDR_W-1:0] A_P1_LO  = {2'b00, IDX_P1_LO, 2'b00};
    localparam logic [ADDR_W-1:0] A_P2     = {2'b00, IDX_P2, 2'b00};
    localparam logic [ADDR_W-1:0] A_P3     = {2'b00, IDX_P3, 2'b00};
    localparam logic [ADDR_W-1:0] A_LEN_01 = {2'b00, IDX_LEN_01, 2'b00};
    localparam logic [ADDR_W-1:0] A_LEN_23 = {2'b00, IDX_LEN_23, 2'b00};

    // software registers
    logic [7:0] sym_freq_q;
    logic [7:0] p0_hi_q;
    logic [7:0] p0_lo_q;
    logic [7:0] p1_hi_q;
    logic [7:0] p1_lo_q;
    logic [7:0] p2_q;
    logic [7:0] p3_q;
    logic [7:0] len_01_q;
    logic [7:0] len_23_q;

    // bus slave state
    logic              pready_q;
    logic              pready_d;
    logic [DATA_W-1:0] prdata_q;
    logic              pslverr_q;
    logic              access;
    logic              wr_fire;
    logic              lane0;
    logic              hit;
    logic [7:0]        rd_byte;

    // encoder-facing flops
    logic        up_sc_q;
    logic [2:0]  up_br_q;
    logic        lo_sc_q;
    logic [2:0]  lo_br_q;
    logic [9:0]  up_sc_khz_q;
    logic [9:0]  up_br_khz_q;
    logic        up_br_ok_q;
    logic [9:0]  lo_sc_khz_q;
    logic [9:0]  lo_br_khz_q;
    logic        lo_br_ok_q;
    logic [15:0] pat0_q;
    logic [15:0] pat1_q;
    logic [7:0]  pat2_q;
    logic [7:0]  pat3_q;
    logic [4:0]  cnt0_q;
    logic [4:0]  cnt1_q;
    logic [3:0]  cnt2_q;
    logic [3:0]  cnt3_q;

    sym_pattern_if pif ();

    // bit-stream code to khz, zero for reserved codes
    function automatic logic [9:0] bitrate_khz(input logic [2:0] code);
        logic [9:0] khz;
        khz = KHZ_NONE;
        case (code)
            3'h2: khz = KHZ_26;
            3'h3: khz = KHZ_53;
            3'h4: khz = KHZ_106;
            3'h5: khz = KHZ_212;
            3'h6: khz = KHZ_424;
            3'h7: khz = KHZ_848;
            default: khz = KHZ_NONE;
        endcase
        return khz;
    endfunction

    // apb decode: one wait state, answer on the second access cycle
    assign access  = psel & penable;
    assign wr_fire = access & pready_q & pwrite;
    assign lane0   = pstrb[0];
    assign pready_d = access & ~pready_q;

    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            A_FREQ:   rd_byte = sym_freq_q;
            A_P0_HI:  rd_byte = p0_hi_q;
            A_P0_LO:  rd_byte = p0_lo_q;
            A_P1_HI:  rd_byte = p1_hi_q;
            A_P1_LO:  rd_byte = p1_lo_q;
            A_P2:     rd_byte = p2_q;
            A_P3:     rd_byte = p3_q;
            A_LEN_01: rd_byte = len_01_q;
            A_LEN_23: rd_byte = len_23_q & LEN_23_MASK;
            default:  hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    // read data and error are loaded together with pready
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (pready_d) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= ~hit;
        end else begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // frequency selections
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sym_freq_q <= RST_BYTE;
        end else if (wr_fire && lane0 && paddr == A_FREQ) begin
            sym_freq_q <= pwdata[7:0];
        end
    end

    // symbol zero pattern bytes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p0_hi_q <= RST_BYTE;
            p0_lo_q <= RST_BYTE;
        end else if (wr_fire && lane0) begin
            if (paddr == A_P0_HI) begin
                p0_hi_q <= pwdata[7:0];
            end
            if (paddr == A_P0_LO) begin
                p0_lo_q <= pwdata[7:0];
            end
        end
    end

    // symbol one pattern bytes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p1_hi_q <= RST_BYTE;
            p1_lo_q <= RST_BYTE;
        end else if (wr_fire && lane0) begin
            if (paddr == A_P1_HI) begin
                p1_hi_q <= pwdata[7:0];
            end
            if (paddr == A_P1_LO) begin
                p1_lo_q <= pwdata[7:0];
            end
        end
    end

    // symbol two and three pattern bytes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p2_q <= RST_BYTE;
            p3_q <= RST_BYTE;
        end else if (wr_fire && lane0) begin
            if (paddr == A_P2) begin
                p2_q <= pwdata[7:0];
            end
            if (paddr == A_P3) begin
                p3_q <= pwdata[7:0];
            end
        end
    end

    // length registers; reserved bits of the upper pair are not stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            len_01_q <= RST_BYTE;
            len_23_q <= RST_BYTE;
        end else if (wr_fire && lane0) begin
            if (paddr == A_LEN_01) begin
                len_01_q <= pwdata[7:0];
            end
            if (paddr == A_LEN_23) begin
                len_23_q <= pwdata[7:0] & LEN_23_MASK;
            end
        end
    end

    // feed the masking unit
    assign pif.raw_zero  = {p0_hi_q, p0_lo_q};
    assign pif.raw_one   = {p1_hi_q, p1_lo_q};
    assign pif.raw_two   = p2_q;
    assign pif.raw_three = p3_q;
    assign pif.len_zero  = len_01_q[LEN0_LSB +: 4];
    assign pif.len_one   = len_01_q[LEN1_LSB +: 4];
    assign pif.len_two   = len_23_q[LEN2_LSB +: 3];
    assign pif.len_three = len_23_q[LEN3_LSB +: 3];

    sym_pattern_mask u_mask (
        .pif (pif.mask)
    );

    // selection fields to the encoder
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            up_sc_q <= 1'b0;
            up_br_q <= 3'h0;
            lo_sc_q <= 1'b0;
            lo_br_q <= 3'h0;
        end else begin
            up_sc_q <= sym_freq_q[UP_SC_POS];
            up_br_q <= sym_freq_q[UP_BR_LSB +: 3];
            lo_sc_q <= sym_freq_q[LO_SC_POS];
            lo_br_q <= sym_freq_q[LO_BR_LSB +: 3];
        end
    end

    // decoded subcarrier frequencies
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            up_sc_khz_q <= KHZ_424;
            lo_sc_khz_q <= KHZ_424;
        end else begin
            up_sc_khz_q <= sym_freq_q[UP_SC_POS] ? KHZ_848 : KHZ_424;
            lo_sc_khz_q <= sym_freq_q[LO_SC_POS] ? KHZ_848 : KHZ_424;
        end
    end

    // decoded bit-stream frequencies and reserved-code flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            up_br_khz_q <= KHZ_NONE;
            lo_br_khz_q <= KHZ_NONE;
            up_br_ok_q  <= 1'b0;
            lo_br_ok_q  <= 1'b0;
        end else begin
            up_br_khz_q <= bitrate_khz(sym_freq_q[UP_BR_LSB +: 3]);
            lo_br_khz_q <= bitrate_khz(sym_freq_q[LO_BR_LSB +: 3]);
            up_br_ok_q  <= sym_freq_q[UP_BR_LSB +: 3] >= BR_FIRST_OK;
            lo_br_ok_q  <= sym_freq_q[LO_BR_LSB +: 3] >= BR_FIRST_OK;
        end
    end

    // masked patterns and valid bit counts
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pat0_q <= 16'h0000;
            pat1_q <= 16'h0000;
            pat2_q <= 8'h00;
            pat3_q <= 8'h00;
            cnt0_q <= 5'h01;
            cnt1_q <= 5'h01;
            cnt2_q <= 4'h1;
            cnt3_q <= 4'h1;
        end else begin
            pat0_q <= pif.cut_zero;
            pat1_q <= pif.cut_one;
            pat2_q <= pif.cut_two;
            pat3_q <= pif.cut_three;
            cnt0_q <= pif.cnt_zero;
            cnt1_q <= pif.cnt_one;
            cnt2_q <= pif.cnt_two;
            cnt3_q <= pif.cnt_three;
        end
    end

    // outputs
    assign prdata                    = prdata_q;
    assign pready                    = pready_q;
    assign pslverr                   = pslverr_q;
    assign upper_pair_subcarrier_sel = up_sc_q;
    assign upper_pair_bitrate_sel    = up_br_q;
    assign lower_pair_subcarrier_sel = lo_sc_q;
    assign lower_pair_bitrate_sel    = lo_br_q;
    assign upper_pair_subcarrier_khz = up_sc_khz_q;
    assign upper_pair_bitrate_khz    = up_br_khz_q;
    assign upper_pair_bitrate_ok     = up_br_ok_q;
    assign lower_pair_subcarrier_khz = lo_sc_khz_q;
    assign lower_pair_bitrate_khz    = lo_br_khz_q;
    assign lower_pair_bitrate_ok     = lo_br_ok_q;
    assign pattern_zero              = pat0_q;
    assign pattern_one               = pat1_q;
    assign pattern_two               = pat2_q;
    assign pattern_three             = pat3_q;
    assign pattern_zero_length       = cnt0_q;
    assign pattern_one_length        = cnt1_q;
    assign pattern_two_length        = cnt2_q;
    assign pattern_three_length      = cnt3_q;

endmodule

`default_nettype wire

// ==== tx_symbol_pattern_config_assertions.sv ====
/*
 * checker for tx_symbol_pattern_config: apb timing, frequency decode,
 * length fields and pattern masking.
 * assumes the top module's port names and sym_cfg_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module tx_symbol_pattern_config_checker
    import sym_cfg_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              upper_pair_subcarrier_sel,
    input wire logic [2:0]        upper_pair_bitrate_sel,
    input wire logic              lower_pair_subcarrier_sel,
    input wire logic [2:0]        lower_pair_bitrate_sel,
    input wire logic [9:0]        upper_pair_subcarrier_khz,
    input wire logic [9:0]        upper_pair_bitrate_khz,
    input wire logic              upper_pair_bitrate_ok,
    input wire logic [9:0]        lower_pair_subcarrier_khz,
    input wire logic [9:0]        lower_pair_bitrate_khz,
    input wire logic              lower_pair_bitrate_ok,
    input wire logic [15:0]       pattern_zero,
    input wire logic [15:0]       pattern_one,
    input wire logic [7:0]        pattern_two,
    input wire logic [7:0]        pattern_three,
    input wire logic [4:0]        pattern_zero_length,
    input wire logic [4:0]        pattern_one_length,
    input wire logic [3:0]        pattern_two_length,
    input wire logic [3:0]        pattern_three_length
);
    localparam logic [9:0] KHZ_TBL [8] = '{KHZ_NONE, KHZ_NONE, KHZ_26, KHZ_53, KHZ_106, KHZ_212, KHZ_424, KHZ_848};
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite && pstrb[0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("error without zero data");
    freq_store_a: assert property (wr_done && paddr == 12'h130 |-> ##2 {upper_pair_subcarrier_sel,
        upper_pair_bitrate_sel, lower_pair_subcarrier_sel, lower_pair_bitrate_sel} == $past(pwdata[7:0], 2))
        else $error("frequency selects not stored");
    upper_decode_a: assert property (upper_pair_bitrate_khz == KHZ_TBL[upper_pair_bitrate_sel]
        && upper_pair_bitrate_ok == (upper_pair_bitrate_sel >= 3'h2)
        && upper_pair_subcarrier_khz == (upper_pair_subcarrier_sel ? KHZ_848 : KHZ_424)) else $error("upper decode");
    lower_decode_a: assert property (lower_pair_bitrate_khz == KHZ_TBL[lower_pair_bitrate_sel]
        && lower_pair_bitrate_ok == (lower_pair_bitrate_sel >= 3'h2)
        && lower_pair_subcarrier_khz == (lower_pair_subcarrier_sel ? KHZ_848 : KHZ_424)) else $error("lower decode");
    len_low_a: assert property (wr_done && paddr == 12'h14c |-> ##2
        pattern_zero_length == 5'($past(pwdata[3:0], 2)) + 5'h1
        && pattern_one_length == 5'($past(pwdata[7:4], 2)) + 5'h1) else $error("length zero one");
    len_high_a: assert property (wr_done && paddr == 12'h150 |-> ##2
        pattern_two_length == 4'($past(pwdata[2:0], 2)) + 4'h1
        && pattern_three_length == 4'($past(pwdata[6:4], 2)) + 4'h1) else $error("length two three");
    len_rsvd_a: assert property (pready && !pwrite && paddr == 12'h150 |-> (prdata & 32'hffff_ff88) == 32'h0000_0000)
        else $error("reserved length bits read back");
    mask_bits_a: assert property ((pattern_zero >> pattern_zero_length) == 16'h0000
        && (pattern_one >> pattern_one_length) == 16'h0000 && (pattern_two >> pattern_two_length) == 8'h00
        && (pattern_three >> pattern_three_length) == 8'h00) else $error("pattern bits beyond length");

    cover property (wr_done && paddr == 12'h14c);
    cover property (pslverr);
    cover property (pready && !pwrite && paddr == 12'h150);
endmodule

bind tx_symbol_pattern_config tx_symbol_pattern_config_checker u_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upper_pair_subcarrier_sel(upper_pair_subcarrier_sel),
    .upper_pair_bitrate_sel(upper_pair_bitrate_sel), .lower_pair_subcarrier_sel(lower_pair_subcarrier_sel),
    .lower_pair_bitrate_sel(lower_pair_bitrate_sel), .upper_pair_subcarrier_khz(upper_pair_subcarrier_khz),
    .upper_pair_bitrate_khz(upper_pair_bitrate_khz), .upper_pair_bitrate_ok(upper_pair_bitrate_ok),
    .lower_pair_subcarrier_khz(lower_pair_subcarrier_khz), .lower_pair_bitrate_khz(lower_pair_bitrate_khz),
    .lower_pair_bitrate_ok(lower_pair_bitrate_ok), .pattern_zero(pattern_zero), .pattern_one(pattern_one),
    .pattern_two(pattern_two), .pattern_three(pattern_three), .pattern_zero_length(pattern_zero_length),
    .pattern_one_length(pattern_one_length), .pattern_two_length(pattern_two_length),
    .pattern_three_length(pattern_three_length));

`default_nettype wire

// ==== tx_symbol_pattern_config_tb_top.sv ====
/*
 * self-checking bench for tx_symbol_pattern_config over apb.
 * assumes sym_cfg_pkg and the checker bound from its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module tx_symbol_pattern_config_tb_top
    import sym_cfg_pkg::*;
;
    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } note_t;
    localparam logic [9:0] KHZ_TBL [8] = '{KHZ_NONE, KHZ_NONE, KHZ_26, KHZ_53, KHZ_106, KHZ_212, KHZ_424, KHZ_848};

    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, us, ls, uok, lok;
    logic [2:0]  ub, lb;
    logic [9:0]  usk, ubk, lsk, lbk;
    logic [15:0] p0, p1;
    logic [7:0]  p2, p3;
    logic [4:0]  n0, n1;
    logic [3:0]  n2, n3;
    note_t       exp_q [$];
    note_t       mon;
    logic [7:0]  shadow [9];
    int          errors = 0;
    int          checks = 0;

    always #5 ref_clk = ~ref_clk;

    tx_symbol_pattern_config u_tx_symbol_pattern_config (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .upper_pair_subcarrier_sel(us), .upper_pair_bitrate_sel(ub),
        .lower_pair_subcarrier_sel(ls), .lower_pair_bitrate_sel(lb), .upper_pair_subcarrier_khz(usk),
        .upper_pair_bitrate_khz(ubk), .upper_pair_bitrate_ok(uok), .lower_pair_subcarrier_khz(lsk),
        .lower_pair_bitrate_khz(lbk), .lower_pair_bitrate_ok(lok), .pattern_zero(p0), .pattern_one(p1),
        .pattern_two(p2), .pattern_three(p3), .pattern_zero_length(n0), .pattern_one_length(n1),
        .pattern_two_length(n2), .pattern_three_length(n3));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [11:0] addr_of(input int i);
        addr_of = {2'b00, IDX_FREQ + 8'(i), 2'b00};
    endfunction

    function automatic logic [15:0] keep(input logic [3:0] f);
        keep = 16'((32'h2 << f) - 1);
    endfunction

    // one apb transfer; the expected data and error are queued for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] rd, input logic err);
        int n;
        exp_q.push_back('{data: rd, err: err});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) check("pready wait", 32'h0000_0000, 32'h0000_0001);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input int i, input logic [7:0] v, input logic [3:0] s);
        apb(1'b1, addr_of(i), {24'($urandom), v}, s, 32'h0000_0000, 1'b0);
        if (s[0]) shadow[i] = (i == 8) ? (v & LEN_23_MASK) : v;
    endtask

    task automatic rd(input int i);
        apb(1'b0, addr_of(i), $urandom, 4'h0, {24'h00_0000, shadow[i]}, 1'b0);
    endtask

    // encoder outputs against the register copies
    task automatic verify();
        logic [7:0] f;
        f = shadow[0];
        @(posedge ref_clk);
        #1;
        check("upper pair", {us, ub, usk, ubk, uok}, {f[7], f[6:4], f[7] ? KHZ_848 : KHZ_424, KHZ_TBL[f[6:4]], f[6:4] >= 3'h2});
        check("lower pair", {ls, lb, lsk, lbk, lok}, {f[3], f[2:0], f[3] ? KHZ_848 : KHZ_424, KHZ_TBL[f[2:0]], f[2:0] >= 3'h2});
        check("lengths", {n0, n1, n2, n3}, {5'(shadow[7][3:0]) + 5'h1, 5'(shadow[7][7:4]) + 5'h1,
            4'(shadow[8][2:0]) + 4'h1, 4'(shadow[8][6:4]) + 4'h1});
        check("pattern zero", 32'(p0), 32'({shadow[1], shadow[2]} & keep(shadow[7][3:0])));
        check("pattern one", 32'(p1), 32'({shadow[3], shadow[4]} & keep(shadow[7][7:4])));
        check("pattern two three", {p2, p3}, {shadow[5] & 8'(keep(4'(shadow[8][2:0]))),
            shadow[6] & 8'(keep(4'(shadow[8][6:4])))});
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            mon = (exp_q.size() > 0) ? exp_q.pop_front() : note_t'{data: 32'hffff_ffff, err: 1'b1};
            check("prdata", prdata, mon.data);
            check("pslverr", {31'h0, pslverr}, {31'h0, mon.err});
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'h231b47e9));
        for (int i = 0; i < 9; i++) shadow[i] = RST_BYTE;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 9; i++) rd(i);
        verify();
        // random bytes written and read back
        for (int i = 0; i < 9; i++) wr(i, 8'($urandom), 4'h1);
        for (int i = 0; i < 9; i++) rd(i);
        verify();
        // every bit-rate code and subcarrier choice in both fields
        for (int c = 0; c < 8; c++) begin
            wr(0, {c[0], 3'(c), ~c[0], 3'(7 - c)}, 4'hf);
            verify();
        end
        // every length against fresh patterns, reserved bits set
        for (int i = 1; i < 7; i++) wr(i, 8'($urandom), 4'hf);
        for (int k = 0; k < 16; k++) begin
            wr(7, {4'(15 - k), 4'(k)}, 4'h1);
            wr(8, {1'b1, 3'(k), 1'b1, 3'(7 - k)}, 4'h1);
            verify();
        end
        rd(8);
        // strobe off, unmapped and unaligned places
        wr(5, ~shadow[5], 4'he);
        rd(5);
        apb(1'b0, 12'h154, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h12c, 32'h0000_00ff, 4'hf, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h131, 32'h0000_00ff, 4'hf, 32'h0000_0000, 1'b1);
        verify();
        // second reset in mid run
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 9; i++) shadow[i] = RST_BYTE;
        verify();
        rd(7);
        repeat (2) @(posedge ref_clk);
        summarize();
    end
endmodule

`default_nettype wire
